/* hw/dtm_pkg.sv */
// Purpose: constants and carrier types for the dual timer mode control
// Assumes: 8-bit register port, 100 MHz core clock
// Notes: every address, field position and count lives here
package dtm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register addresses
    localparam logic [7:0] ADDR_RUN_CTRL = 8'h88;
    localparam logic [7:0] ADDR_MODE_CFG = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW = 8'h8a;
    localparam logic [7:0] ADDR_T1_LOW = 8'h8b;
    localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
    localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h90;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h91;

    ////////////////////////////////////////////////////////////////////////
    // field positions in the run control register
    localparam int RUN_T1_FLAG_BIT = 7;
    localparam int RUN_T1_RUN_BIT = 6;
    localparam int RUN_T0_FLAG_BIT = 5;
    localparam int RUN_T0_RUN_BIT = 4;

    // field positions in the irq status and mask registers
    localparam int IRQ_T0_BIT = 0;
    localparam int IRQ_T1_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_MODE_CFG = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [1:0] RST_RUN = 2'h0;
    localparam logic [1:0] RST_FLAG = 2'h0;
    localparam logic [1:0] RST_MASK = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // operating modes of the per-timer mode field
    localparam logic [1:0] MODE_PRESCALED = 2'h0;
    localparam logic [1:0] MODE_WIDE = 2'h1;
    localparam logic [1:0] MODE_AUTO_RELOAD = 2'h2;
    localparam logic [1:0] MODE_STOPPED = 2'h3;

    // prescaler width in the low byte for the prescaled mode
    localparam logic [4:0] PRESCALE_MAX = 5'h1f;
    localparam logic [7:0] BYTE_MAX = 8'hff;

    ////////////////////////////////////////////////////////////////////////
    // timing: the internal time base advances once per this many clocks
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_CYCLES = 2;
    localparam int TICK_NS = TICK_CYCLES * CLK_PERIOD_NS;
    localparam int TICK_DIV = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);

    ////////////////////////////////////////////////////////////////////////
    // per-timer configuration, four bits of the mode register
    typedef struct packed {
        logic pin_gating;
        logic source_select;
        logic [1:0] mode_field;
    } dtm_tcfg_type;

    // whole mode register, timer 1 in the upper nibble
    typedef struct packed {
        dtm_tcfg_type timer1;
        dtm_tcfg_type timer0;
    } dtm_mode_cfg_type;

    // one timer's count pair and its overflow out of a step
    typedef struct packed {
        logic [7:0] high_byte;
        logic [7:0] low_byte;
        logic overflow;
    } dtm_step_type;

endpackage : dtm_pkg

/* hw/dtm_timer_mode_ctrl.sv */
// Purpose: dual timer/counter with mode control, gating and overflow irq
// Assumes: pins are synchronous to i_core_clk; one clock, sync reset
// Notes: reads return data in the cycle after the read strobe only
//
// Overview of operation
// - timer 1 ungated counts whenever its run bit is set, except in mode 11.
// - timer 1 gated counts only with run set and irq pin 1 high.
// - timer 1 internal source advances once every 2 clocks.
// - timer 1 external source advances on count pin 1 falling edges.
// - timer 1 mode 00 is 8-bit plus 5-bit prescaler; 01 is 16-bit.
// - timer 1 mode 10 counts low byte, reloads from high on overflow.
// - timer 0 ungated counts whenever its run bit is set, except in mode 11.
// - timer 0 gated counts only with run set and irq pin 0 high.
// - timer 0 internal source advances once every 2 clocks.
// - timer 0 external source advances on count pin 0 falling edges.
// - timer 0 mode 00 is 8-bit plus 5-bit prescaler; 01 is 16-bit.
// - timer 0 mode 10 counts low byte, reloads from high on overflow.
// - run bit cleared stops a timer; set lets it run when gated open, except in mode 11.
// - overflow sets the flag; vectoring into the handler clears it.
`timescale 1ns/100ps

module dtm_timer_mode_ctrl (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [7:0] o_rd_data,
    // external pins
    input wire logic i_ext_irq_pin_0,
    input wire logic i_ext_irq_pin_1,
    input wire logic i_ext_count_pin_0,
    input wire logic i_ext_count_pin_1,
    // interrupt vector acknowledge from the processor
    input wire logic i_timer0_vector_ack,
    input wire logic i_timer1_vector_ack,
    // status outputs
    output logic o_timer0_overflow_flag,
    output logic o_timer1_overflow_flag,
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // one counting step of a timer in the given mode
    function automatic dtm_pkg::dtm_step_type dtm_next(
        input logic [1:0] mode,
        input logic [7:0] hi,
        input logic [7:0] lo
    );
        dtm_pkg::dtm_step_type res;
        logic [16:0] wide;
        res.high_byte = hi;
        res.low_byte = lo;
        res.overflow = 1'b0;
        wide = 17'h00000;
        unique case (mode)
            dtm_pkg::MODE_PRESCALED: begin
                // upper three low-byte bits are left untouched
                res.low_byte[4:0] = 5'(lo[4:0] + 5'h01);
                if (lo[4:0] == dtm_pkg::PRESCALE_MAX) begin
                    res.high_byte = 8'(hi + 8'h01);
                    res.overflow = (hi == dtm_pkg::BYTE_MAX);
                end
            end
            dtm_pkg::MODE_WIDE: begin
                wide = {1'b0, hi, lo} + 17'h00001;
                res.high_byte = wide[15:8];
                res.low_byte = wide[7:0];
                res.overflow = wide[16];
            end
            dtm_pkg::MODE_AUTO_RELOAD: begin
                if (lo == dtm_pkg::BYTE_MAX) begin
                    res.low_byte = hi;
                    res.overflow = 1'b1;
                end else begin
                    res.low_byte = 8'(lo + 8'h01);
                end
            end
            dtm_pkg::MODE_STOPPED: begin
                res.overflow = 1'b0;
            end
        endcase
        return res;
    endfunction : dtm_next

    // one strobe qualified by an exact address match
    function automatic logic dtm_hit(
        input logic strobe,
        input logic [7:0] addr,
        input logic [7:0] target
    );
        return strobe && (addr == target);
    endfunction : dtm_hit

    ////////////////////////////////////////////////////////////////////////
    // registers
    dtm_pkg::dtm_mode_cfg_type cfg_q;
    dtm_pkg::dtm_tcfg_type tcfg [2];
    logic [1:0] run_q;
    logic [1:0] flag_q;
    logic [1:0] flag_d;
    logic [1:0] mask_q;
    logic [7:0] high_q [2];
    logic [7:0] low_q [2];
    logic [1:0] div_q;
    logic tick;
    logic [1:0] count_pin;
    logic [1:0] count_pin_prev_q;
    logic [1:0] count_edge;
    logic [1:0] irq_pin;
    logic [1:0] vector_ack;
    logic [1:0] gate_open;
    logic [1:0] advance;
    logic [1:0] count_en;
    logic [1:0] overflow_evt;
    logic [1:0] flag_clr;
    logic [1:0] wr_low;
    logic [1:0] wr_high;
    logic wr_run_ctrl;
    logic wr_mode_cfg;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic [7:0] rd_mux;
    dtm_pkg::dtm_step_type step [2];

    assign tcfg[0] = cfg_q.timer0;
    assign tcfg[1] = cfg_q.timer1;
    assign count_pin = {i_ext_count_pin_1, i_ext_count_pin_0};
    assign irq_pin = {i_ext_irq_pin_1, i_ext_irq_pin_0};
    assign vector_ack = {i_timer1_vector_ack, i_timer0_vector_ack};
    assign wr_low[0] = dtm_hit(i_wr_en, i_addr, dtm_pkg::ADDR_T0_LOW);
    assign wr_low[1] = dtm_hit(i_wr_en, i_addr, dtm_pkg::ADDR_T1_LOW);
    assign wr_high[0] = dtm_hit(i_wr_en, i_addr, dtm_pkg::ADDR_T0_HIGH);
    assign wr_high[1] = dtm_hit(i_wr_en, i_addr, dtm_pkg::ADDR_T1_HIGH);
    assign wr_run_ctrl = dtm_hit(i_wr_en, i_addr, dtm_pkg::ADDR_RUN_CTRL);
    assign wr_mode_cfg = dtm_hit(i_wr_en, i_addr, dtm_pkg::ADDR_MODE_CFG);
    assign wr_irq_status = dtm_hit(i_wr_en, i_addr, dtm_pkg::ADDR_IRQ_STATUS);
    assign wr_irq_mask = dtm_hit(i_wr_en, i_addr, dtm_pkg::ADDR_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////
    // free-running time base: one pulse every TICK_DIV clocks
    // it is not restarted by the run bit, so the first step may come one
    // clock sooner than the two-clock spacing of the rest; a run of 2n clocks gives n steps
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            div_q <= 2'h0;
        end else if (div_q == dtm_pkg::TICK_LAST) begin
            div_q <= 2'h0;
        end else begin
            div_q <= 2'(div_q + 2'h1);
        end
    end

    assign tick = (div_q == dtm_pkg::TICK_LAST);

    ////////////////////////////////////////////////////////////////////////
    // count pin edge detect; pins are already synchronous, so one stage
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            count_pin_prev_q <= 2'h0;
        end else begin
            count_pin_prev_q <= count_pin;
        end
    end

    // a pin held low through reset release gives no spurious edge
    assign count_edge = count_pin_prev_q & ~count_pin;

    ////////////////////////////////////////////////////////////////////////
    // gating, source and mode decide whether a timer steps this cycle
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            gate_open[i] = run_q[i] & (~tcfg[i].pin_gating | irq_pin[i]);
            advance[i] = tcfg[i].source_select ? count_edge[i] : tick;
            count_en[i] = gate_open[i] & advance[i]
                & (tcfg[i].mode_field != dtm_pkg::MODE_STOPPED);
        end
    end

    // the step is worked out every cycle and kept only when enabled
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            step[i] = dtm_next(tcfg[i].mode_field, high_q[i], low_q[i]);
            overflow_evt[i] = count_en[i] & step[i].overflow;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // count bytes; a software write wins over a count in the same cycle,
    // while the byte not written still takes its step
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            for (int i = 0; i < 2; i++) begin
                low_q[i] <= dtm_pkg::RST_COUNT;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_low[i]) begin
                    low_q[i] <= i_wr_data;
                end else if (count_en[i]) begin
                    low_q[i] <= step[i].low_byte;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            for (int i = 0; i < 2; i++) begin
                high_q[i] <= dtm_pkg::RST_COUNT;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_high[i]) begin
                    high_q[i] <= i_wr_data;
                end else if (count_en[i]) begin
                    high_q[i] <= step[i].high_byte;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode configuration register
    // a new mode acts from the next step; the count bytes are kept as is
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cfg_q <= dtm_pkg::RST_MODE_CFG;
        end else if (wr_mode_cfg) begin
            cfg_q <= i_wr_data;
        end
    end

    // run control bits; the flag positions of this register are read-only
    // clearing a run bit freezes its timer at the value of its last step
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            run_q <= dtm_pkg::RST_RUN;
        end else if (wr_run_ctrl) begin
            run_q[0] <= i_wr_data[dtm_pkg::RUN_T0_RUN_BIT];
            run_q[1] <= i_wr_data[dtm_pkg::RUN_T1_RUN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // overflow flags: set by overflow, cleared by vector ack or write-one;
    // a set in the clearing cycle wins so no overflow is lost
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            flag_clr[i] = vector_ack[i];
        end
        if (wr_irq_status) begin
            flag_clr[0] = flag_clr[0] | i_wr_data[dtm_pkg::IRQ_T0_BIT];
            flag_clr[1] = flag_clr[1] | i_wr_data[dtm_pkg::IRQ_T1_BIT];
        end
        flag_d = overflow_evt | (flag_q & ~flag_clr);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            flag_q <= dtm_pkg::RST_FLAG;
        end else begin
            flag_q <= flag_d;
        end
    end

    // masking only hides the interrupt; flags still record every overflow
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mask_q <= dtm_pkg::RST_MASK;
        end else if (wr_irq_mask) begin
            mask_q[0] <= i_wr_data[dtm_pkg::IRQ_T0_BIT];
            mask_q[1] <= i_wr_data[dtm_pkg::IRQ_T1_BIT];
        end
    end

    assign o_timer0_overflow_flag = flag_q[0];
    assign o_timer1_overflow_flag = flag_q[1];
    // level interrupt; it drops as soon as every unmasked flag is cleared
    assign o_irq = |(flag_q & mask_q);

    ////////////////////////////////////////////////////////////////////////
    // read path: unmapped addresses read zero
    // reads have no side effects; flags clear only by w1c or vector ack
    always_comb begin
        rd_mux = 8'h00;
        unique case (i_addr)
            dtm_pkg::ADDR_RUN_CTRL: begin
                rd_mux[dtm_pkg::RUN_T1_FLAG_BIT] = flag_q[1];
                rd_mux[dtm_pkg::RUN_T1_RUN_BIT] = run_q[1];
                rd_mux[dtm_pkg::RUN_T0_FLAG_BIT] = flag_q[0];
                rd_mux[dtm_pkg::RUN_T0_RUN_BIT] = run_q[0];
            end
            dtm_pkg::ADDR_MODE_CFG: begin
                rd_mux = cfg_q;
            end
            dtm_pkg::ADDR_T0_LOW: begin
                rd_mux = low_q[0];
            end
            dtm_pkg::ADDR_T1_LOW: begin
                rd_mux = low_q[1];
            end
            dtm_pkg::ADDR_T0_HIGH: begin
                rd_mux = high_q[0];
            end
            dtm_pkg::ADDR_T1_HIGH: begin
                rd_mux = high_q[1];
            end
            dtm_pkg::ADDR_IRQ_STATUS: begin
                rd_mux[dtm_pkg::IRQ_T0_BIT] = flag_q[0];
                rd_mux[dtm_pkg::IRQ_T1_BIT] = flag_q[1];
            end
            dtm_pkg::ADDR_IRQ_MASK: begin
                rd_mux[dtm_pkg::IRQ_T0_BIT] = mask_q[0];
                rd_mux[dtm_pkg::IRQ_T1_BIT] = mask_q[1];
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_rd_data <= 8'h00;
        end else if (i_rd_en) begin
            o_rd_data <= rd_mux;
        end else begin
            o_rd_data <= 8'h00;
        end
    end

endmodule : dtm_timer_mode_ctrl

/* verification/dtm_timer_mode_ctrl_assertions.sv */
// Purpose: port-level checks for the dual timer mode control
// Assumes: one clock domain, synchronous active-high reset
// Notes: counts are not visible here; flags, irq and reads are
`timescale 1ns/100ps

module dtm_timer_mode_ctrl_checker (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] o_rd_data,
    // flags and interrupt
    input wire logic i_timer0_vector_ack,
    input wire logic i_timer1_vector_ack,
    input wire logic o_timer0_overflow_flag,
    input wire logic o_timer1_overflow_flag,
    input wire logic o_irq
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic st_wr;
    logic mask_wr;
    logic [1:0] flags;
    assign st_wr = i_wr_en && i_addr == dtm_pkg::ADDR_IRQ_STATUS;
    assign mask_wr = i_wr_en && i_addr == dtm_pkg::ADDR_IRQ_MASK;
    assign flags = {o_timer1_overflow_flag, o_timer0_overflow_flag};
    ////////////////////////////////////////
    chk_read_idle_zero: assert property (
        !$past(i_rd_en) |-> o_rd_data == 8'h00)
        else $error("read data not zero outside a read");
    chk_unmapped_read: assert property (
        i_rd_en && i_addr == 8'h00 |=> o_rd_data == 8'h00)
        else $error("unmapped read returned data");
    chk_status_mirror: assert property (
        i_rd_en && i_addr == dtm_pkg::ADDR_IRQ_STATUS
        |=> o_rd_data == {6'h00, $past(flags)})
        else $error("status read differs from flags");
    chk_mode_readback: assert property (
        i_wr_en && i_addr == dtm_pkg::ADDR_MODE_CFG ##2
        i_rd_en && i_addr == dtm_pkg::ADDR_MODE_CFG
        |=> o_rd_data == $past(i_wr_data, 3))
        else $error("mode config readback differs");
    chk_flag0_clear: assert property (
        $fell(o_timer0_overflow_flag) |-> $past(i_timer0_vector_ack)
        || $past(st_wr && i_wr_data[0]) || $past(i_rst))
        else $error("timer0 flag fell without a clear");
    chk_flag1_clear: assert property (
        $fell(o_timer1_overflow_flag) |-> $past(i_timer1_vector_ack)
        || $past(st_wr && i_wr_data[1]) || $past(i_rst))
        else $error("timer1 flag fell without a clear");
    chk_flag0_sticky: assert property (
        o_timer0_overflow_flag && !i_timer0_vector_ack
        && !(st_wr && i_wr_data[0]) |=> o_timer0_overflow_flag)
        else $error("timer0 flag not held");
    chk_flag1_sticky: assert property (
        o_timer1_overflow_flag && !i_timer1_vector_ack
        && !(st_wr && i_wr_data[1]) |=> o_timer1_overflow_flag)
        else $error("timer1 flag not held");
    chk_irq_mask_off: assert property (
        mask_wr && i_wr_data[1:0] == 2'h0 |=> !o_irq)
        else $error("irq high with all sources masked");
    chk_irq_mask_on: assert property (
        mask_wr && i_wr_data[1:0] == 2'h3 && (|flags)
        && !i_timer0_vector_ack && !i_timer1_vector_ack |=> o_irq)
        else $error("irq low with unmasked flag set");
    cover property ($rose(o_timer0_overflow_flag));
    cover property ($rose(o_timer1_overflow_flag));
    cover property ($rose(o_irq));
    cover property ($fell(o_irq));
endmodule : dtm_timer_mode_ctrl_checker

bind dtm_timer_mode_ctrl dtm_timer_mode_ctrl_checker u_chk (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .o_rd_data(o_rd_data), .i_timer0_vector_ack(i_timer0_vector_ack),
    .i_timer1_vector_ack(i_timer1_vector_ack),
    .o_timer0_overflow_flag(o_timer0_overflow_flag),
    .o_timer1_overflow_flag(o_timer1_overflow_flag), .o_irq(o_irq)
);

/* verification/dtm_pin_partner.sv */
// Purpose: far-side model of the gate and count pins
// Assumes: pins change just after the rising clock edge
// Notes: count pins idle low, so each pulse gives exactly one fall
`timescale 1ns/100ps

module dtm_pin_partner (
    // clock
    input wire logic i_core_clk,
    // pins toward the timer block
    output logic [1:0] o_gate_pins,
    output logic [1:0] o_count_pins
);
    initial begin
        o_gate_pins = 2'h0;
        o_count_pins = 2'h0;
    end

    task automatic set_gate(input int t, input logic v);
        @(posedge i_core_clk);
        o_gate_pins[t] <= v;
    endtask : set_gate

    // hold 1 is a prompt source, larger values a slow one
    task automatic pulses(input int t, input int n, input int hold);
        for (int i = 0; i < n; i++) begin
            @(posedge i_core_clk);
            o_count_pins[t] <= 1'b1;
            repeat (hold) @(posedge i_core_clk);
            o_count_pins[t] <= 1'b0;
            repeat (hold) @(posedge i_core_clk);
        end
    endtask : pulses
endmodule : dtm_pin_partner

/* verification/dtm_timer_mode_ctrl_test.sv */
// Purpose: self-checking bench for the dual timer mode control
// Assumes: read data stands only in the cycle after the read strobe
// Notes: counts are read back after the run bit is cleared
`timescale 1ns/100ps

module dtm_timer_mode_ctrl_test;
    localparam int MAX_CYCLES = 20000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wd = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [1:0] ack = 2'h0;
    logic [7:0] rdata;
    logic [1:0] gate;
    logic [1:0] cnt;
    logic [1:0] fl;
    logic irq;
    logic [7:0] v;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    dtm_timer_mode_ctrl dut (
        .i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wr_data(wd),
        .i_wr_en(we), .i_rd_en(re), .o_rd_data(rdata),
        .i_ext_irq_pin_0(gate[0]), .i_ext_irq_pin_1(gate[1]),
        .i_ext_count_pin_0(cnt[0]), .i_ext_count_pin_1(cnt[1]),
        .i_timer0_vector_ack(ack[0]), .i_timer1_vector_ack(ack[1]),
        .o_timer0_overflow_flag(fl[0]), .o_timer1_overflow_flag(fl[1]),
        .o_irq(irq)
    );
    dtm_pin_partner pm (
        .i_core_clk(clk), .o_gate_pins(gate), .o_count_pins(cnt)
    );
    ////////////////////////////////////////
    task automatic chk8(input string n, input logic [7:0] e,
        input logic [7:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk8

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic vec_ack(input int t);
        @(posedge clk);
        ack[t] <= 1'b1;
        @(posedge clk);
        ack[t] <= 1'b0;
        #1;
    endtask : vec_ack

    // n is clock edges with run set, or pulses for the external source
    task automatic tm(input int t, input logic [3:0] cfg,
        input logic [7:0] hi, input logic [7:0] lo, input int n,
        input logic [7:0] ehi, input logic [7:0] elo);
        wr(dtm_pkg::ADDR_MODE_CFG, t ? {cfg, 4'h0} : {4'h0, cfg});
        wr(dtm_pkg::ADDR_T0_HIGH + 8'(t), hi);
        wr(dtm_pkg::ADDR_T0_LOW + 8'(t), lo);
        wr(dtm_pkg::ADDR_RUN_CTRL, t ? 8'h40 : 8'h10);
        if (cfg[2]) pm.pulses(t, n, 2 * t + 1);
        else repeat (n - 2) @(posedge clk);
        wr(dtm_pkg::ADDR_RUN_CTRL, 8'h00);
        rd(dtm_pkg::ADDR_T0_HIGH + 8'(t), v);
        chk8("high byte", ehi, v);
        rd(dtm_pkg::ADDR_T0_LOW + 8'(t), v);
        chk8("low byte", elo, v);
    endtask : tm
    ////////////////////////////////////////
    task automatic s_regs();
        logic [7:0] al [9] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
            8'h90, 8'h91, 8'h00};
        foreach (al[i]) begin
            rd(al[i], v);
            chk8("reset value", 8'h00, v);
        end
        wr(dtm_pkg::ADDR_MODE_CFG, 8'ha5);
        rd(dtm_pkg::ADDR_MODE_CFG, v);
        chk8("mode config", 8'ha5, v);
        wr(8'h00, 8'hff);
        rd(8'h00, v);
        chk8("unmapped", 8'h00, v);
        wr(dtm_pkg::ADDR_RUN_CTRL, 8'hff);
        rd(dtm_pkg::ADDR_RUN_CTRL, v);
        chk8("run control", 8'h50, v);
        wr(dtm_pkg::ADDR_RUN_CTRL, 8'h00);
    endtask : s_regs

    task automatic s_gating();
        for (int t = 0; t < 2; t++) begin
            pm.set_gate(t, 1'b0);
            tm(t, 4'h9, 8'h00, 8'h00, 20, 8'h00, 8'h00);
            pm.set_gate(t, 1'b1);
            tm(t, 4'h9, 8'h00, 8'h00, 20, 8'h00, 8'h0a);
            pm.set_gate(t, 1'b0);
            tm(t, 4'h1, 8'h00, 8'h00, 20, 8'h00, 8'h0a);
        end
    endtask : s_gating

    task automatic s_modes();
        for (int t = 0; t < 2; t++) begin
            tm(t, 4'h1, 8'h00, 8'hff, 2, 8'h01, 8'h00);
            tm(t, 4'h0, 8'h05, 8'hfe, 4, 8'h06, 8'he0);
            tm(t, 4'h2, 8'h80, 8'hfe, 6, 8'h80, 8'h81);
            tm(t, 4'h3, 8'h12, 8'h34, 20, 8'h12, 8'h34);
            tm(t, 4'h5, 8'h00, 8'h00, 3, 8'h00, 8'h03);
        end
    endtask : s_modes

    task automatic s_irq();
        for (int t = 0; t < 2; t++) begin
            wr(dtm_pkg::ADDR_IRQ_STATUS, 8'h03);
            tm(t, 4'h1, 8'hff, 8'hff, 2, 8'h00, 8'h00);
            chk8("flag", 8'h01, {7'h00, fl[t]});
            chk8("irq masked", 8'h00, {7'h00, irq});
            rd(dtm_pkg::ADDR_IRQ_STATUS, v);
            chk8("status", 8'h01 << t, v);
            rd(dtm_pkg::ADDR_RUN_CTRL, v);
            chk8("flag mirror", t ? 8'h80 : 8'h20, v);
            wr(dtm_pkg::ADDR_IRQ_MASK, 8'h03);
            chk8("irq", 8'h01, {7'h00, irq});
            vec_ack(t);
            chk8("flag after ack", 8'h00, {7'h00, fl[t]});
            chk8("irq after ack", 8'h00, {7'h00, irq});
            tm(t, 4'h2, 8'h40, 8'hff, 2, 8'h40, 8'h40);
            chk8("irq after reload", 8'h01, {7'h00, irq});
            wr(dtm_pkg::ADDR_IRQ_STATUS, 8'h01 << t);
            chk8("flag after w1c", 8'h00, {7'h00, fl[t]});
            chk8("irq after w1c", 8'h00, {7'h00, irq});
            wr(dtm_pkg::ADDR_IRQ_MASK, 8'h00);
        end
    endtask : s_irq
    ////////////////////////////////////////
    task automatic final_report();
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == MAX_CYCLES) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        s_regs();
        s_gating();
        s_modes();
        s_irq();
        final_report();
    end
endmodule : dtm_timer_mode_ctrl_test
